// ==== cpw_cfg.svh ====
// Register offsets, field positions and reset values of the channel power bank
`ifndef CPW_CFG_SVH
`define CPW_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CPW_ADDR_INPUT_CHANNEL_ENABLE 8'h73
`define CPW_ADDR_SLOT_OUTPUT_ENABLE 8'h74
`define CPW_ADDR_POWER_UP_CONFIG 8'h75
`define CPW_ADDR_CHANNEL_POWER_STATUS 8'h76

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CPW_RST_INPUT_CHANNEL_ENABLE 8'hf0
`define CPW_RST_SLOT_OUTPUT_ENABLE 8'h00
`define CPW_RST_POWER_UP_CONFIG 8'h00
`define CPW_RST_CHANNEL_POWER_STATUS 8'h00
`define CPW_READ_ZERO 8'h00

// ----------------------------------------------------------------
// Power-up register fields
// ----------------------------------------------------------------
`define CPW_BIT_MIC_BIAS 7
`define CPW_BIT_CONVERTER 6
`define CPW_BIT_CLOCK_SYNTH 5
`define CPW_BIT_LIVE_SWITCH 4
`define CPW_GROUP_HI 3
`define CPW_GROUP_LO 2

// ----------------------------------------------------------------
// Channel masks, channel 1 at bit 7
// ----------------------------------------------------------------
`define CPW_MASK_CH1_2 8'hc0
`define CPW_MASK_CH1_4 8'hf0
`define CPW_MASK_CH1_6 8'hfc
`define CPW_MASK_CH1_8 8'hff
`define CPW_MASK_CH1 8'h80
`define CPW_MASK_NONE 8'h00
`define CPW_PDM_ONLY_FILL 4'hf

`endif

// ==== cpw_pkg.sv ====
// Types shared by the channel power bank modules
package cpw_pkg;

    typedef logic [7:0] cpw_byte_type;

    typedef enum logic [1:0] {
        CPW_GROUP_CH1_2,
        CPW_GROUP_CH1_4,
        CPW_GROUP_CH1_6,
        CPW_GROUP_CH1_8
    } cpw_group_type;

endpackage

// ==== cpw_chan_power.sv ====
// Per-channel power sequencing from enables and power-up settings
`include "cpw_cfg.svh"

module cpw_chan_power
    import cpw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Settings
    input wire cpw_byte_type input_enable,
    input wire logic converter_power_on,
    input wire logic live_channel_power_switch,
    input wire cpw_group_type live_channel_group_select,
    // Power state
    output cpw_byte_type channel_power_flag
);

    // ----------------------------------------------------------------
    // Group decode
    // ----------------------------------------------------------------
    function automatic cpw_byte_type group_mask(input cpw_group_type sel);
        case (sel)
            CPW_GROUP_CH1_2: group_mask = `CPW_MASK_CH1_2;
            CPW_GROUP_CH1_4: group_mask = `CPW_MASK_CH1_4;
            CPW_GROUP_CH1_6: group_mask = `CPW_MASK_CH1_6;
            CPW_GROUP_CH1_8: group_mask = `CPW_MASK_CH1_8;
            default: group_mask = `CPW_MASK_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Power state
    // ----------------------------------------------------------------
    cpw_byte_type power_r;
    cpw_byte_type power_nxt;
    cpw_byte_type grp;
    logic recording;

    assign grp = group_mask(live_channel_group_select);
    assign recording = |power_r;

    always_comb begin
        if (!converter_power_on) begin
            power_nxt = `CPW_MASK_NONE;
        end else if (!recording) begin
            power_nxt = input_enable;
        end else if (live_channel_power_switch) begin
            // Only the selected group may change while recording
            power_nxt = (input_enable & grp) | (power_r & ~grp);
        end else begin
            // Frozen while recording: switching now would glitch live channels
            power_nxt = power_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            power_r <= `CPW_RST_CHANNEL_POWER_STATUS;
        end else begin
            power_r <= power_nxt;
        end
    end

    assign channel_power_flag = power_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_power_down_all: assert property (@(posedge clk_sys) disable iff (reset)
        !converter_power_on |=> power_r == `CPW_MASK_NONE)
        else $error("channels still powered after converter power down");

    a_power_subset_en: assert property (@(posedge clk_sys) disable iff (reset)
        converter_power_on && !recording |=> power_r == $past(input_enable))
        else $error("powered channels differ from enables");

    a_frozen_recording: assert property (@(posedge clk_sys) disable iff (reset)
        converter_power_on && recording && !live_channel_power_switch
        |=> power_r == $past(power_r))
        else $error("channel power changed while recording without live mode");

    a_group_outside_held: assert property (@(posedge clk_sys) disable iff (reset)
        converter_power_on && recording && live_channel_power_switch
        |=> (power_r & ~$past(grp)) == ($past(power_r) & ~$past(grp)))
        else $error("channel outside live group changed while recording");

endmodule

// ==== cpw_top.sv ====
// Channel enable, serial slot enable and power-up register bank
// Contract
// - One input enable bit per channel, ch1 at bit 7; reset enables 1-4.
// - Channels 5 to 8 serve only PDM microphones, never analog converters.
// - Slot drive bit 1 drives that channel's serial slot; 0 tri-states it.
// - All slot drive bits reset to 0, so every slot is tri-stated.
// - Power-up bit 7 switches the microphone bias supply on or off.
// - Bit 6 low powers down all channels; high, when none are on, powers exactly the enabled ones.
// - Power-up bit 5 switches the internal PLL on or off.
// - With live switch off and bit 6 high, channel power cannot change while recording.
// - Bits 3:2 select channel group 1-2, 1-4, 1-6 or 1-8 for live switching.
// - Power-up register resets to zero; bits 1:0 reserved.
// - Read-only status shows each channel's actual power state.
`include "cpw_cfg.svh"

module cpw_top
    import cpw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port from the control interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Source select for channels 1-4, 1 = PDM, same clock domain
    input wire logic [3:0] ch_pdm_select,
    // Audio serial port slot timing and data
    input wire logic [7:0] slot_active,
    input wire logic slot_data,
    output logic sdout,
    output logic sdout_oe,
    // Power controls
    output logic mic_bias_power_on,
    output logic clock_synth_power_on,
    output logic [3:0] analog_ch_power_on,
    output logic [7:0] pdm_ch_power_on
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    cpw_byte_type in_en_r;
    cpw_byte_type in_en_nxt;
    cpw_byte_type slot_en_r;
    cpw_byte_type slot_en_nxt;
    cpw_byte_type pwr_r;
    cpw_byte_type pwr_nxt;
    cpw_byte_type rdata_r;
    cpw_byte_type rdata_nxt;
    cpw_byte_type status;
    cpw_group_type group_sel;

    assign group_sel = cpw_group_type'(pwr_r[`CPW_GROUP_HI:`CPW_GROUP_LO]);

    always_comb begin
        in_en_nxt = in_en_r;
        slot_en_nxt = slot_en_r;
        pwr_nxt = pwr_r;
        rdata_nxt = rdata_r;
        if (reg_wr) begin
            case (reg_addr)
                `CPW_ADDR_INPUT_CHANNEL_ENABLE: in_en_nxt = reg_wdata;
                `CPW_ADDR_SLOT_OUTPUT_ENABLE: slot_en_nxt = reg_wdata;
                // Reserved bits are stored as written
                `CPW_ADDR_POWER_UP_CONFIG: pwr_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `CPW_ADDR_INPUT_CHANNEL_ENABLE: rdata_nxt = in_en_r;
                `CPW_ADDR_SLOT_OUTPUT_ENABLE: rdata_nxt = slot_en_r;
                `CPW_ADDR_POWER_UP_CONFIG: rdata_nxt = pwr_r;
                `CPW_ADDR_CHANNEL_POWER_STATUS: rdata_nxt = status;
                default: rdata_nxt = `CPW_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            in_en_r <= `CPW_RST_INPUT_CHANNEL_ENABLE;
            slot_en_r <= `CPW_RST_SLOT_OUTPUT_ENABLE;
            pwr_r <= `CPW_RST_POWER_UP_CONFIG;
            rdata_r <= `CPW_READ_ZERO;
        end else begin
            in_en_r <= in_en_nxt;
            slot_en_r <= slot_en_nxt;
            pwr_r <= pwr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Channel power
    // ----------------------------------------------------------------
    cpw_chan_power u_chan_power (
        .clk_sys(clk_sys),
        .reset(reset),
        .input_enable(in_en_r),
        .converter_power_on(pwr_r[`CPW_BIT_CONVERTER]),
        .live_channel_power_switch(pwr_r[`CPW_BIT_LIVE_SWITCH]),
        .live_channel_group_select(group_sel),
        .channel_power_flag(status)
    );

    // ----------------------------------------------------------------
    // Power outputs and serial slot drive
    // ----------------------------------------------------------------
    logic [3:0] analog_nxt;
    cpw_byte_type pdm_nxt;
    logic sdout_nxt;
    logic sdout_oe_nxt;
    logic [3:0] analog_r;
    cpw_byte_type pdm_r;
    logic sdout_r;
    logic sdout_oe_r;
    logic bias_r;
    logic synth_r;
    logic bias_nxt;
    logic synth_nxt;

    always_comb begin
        // Only channels 1-4 have analog front ends
        analog_nxt = status[7:4] & ~ch_pdm_select;
        pdm_nxt = status & {ch_pdm_select, `CPW_PDM_ONLY_FILL};
        sdout_oe_nxt = |(slot_active & slot_en_r);
        sdout_nxt = sdout_oe_nxt & slot_data;
        bias_nxt = pwr_r[`CPW_BIT_MIC_BIAS];
        synth_nxt = pwr_r[`CPW_BIT_CLOCK_SYNTH];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            analog_r <= '0;
            pdm_r <= `CPW_MASK_NONE;
            sdout_r <= 1'b0;
            sdout_oe_r <= 1'b0;
            bias_r <= 1'b0;
            synth_r <= 1'b0;
        end else begin
            analog_r <= analog_nxt;
            pdm_r <= pdm_nxt;
            sdout_r <= sdout_nxt;
            sdout_oe_r <= sdout_oe_nxt;
            bias_r <= bias_nxt;
            synth_r <= synth_nxt;
        end
    end

    assign analog_ch_power_on = analog_r;
    assign pdm_ch_power_on = pdm_r;
    assign sdout = sdout_r;
    assign sdout_oe = sdout_oe_r;
    assign mic_bias_power_on = bias_r;
    assign clock_synth_power_on = synth_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_bias_follows_bit: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 mic_bias_power_on == $past(pwr_r[`CPW_BIT_MIC_BIAS]))
        else $error("mic bias does not follow its control bit");

    a_synth_follows_bit: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 clock_synth_power_on == $past(pwr_r[`CPW_BIT_CLOCK_SYNTH]))
        else $error("PLL power does not follow its control bit");

    a_slot_tristate: assert property (@(posedge clk_sys) disable iff (reset)
        (slot_active & slot_en_r) == `CPW_MASK_NONE |=> !sdout_oe)
        else $error("disabled slot is driven");

    a_slot_driven: assert property (@(posedge clk_sys) disable iff (reset)
        (slot_active & slot_en_r) != `CPW_MASK_NONE |=> sdout_oe && sdout == $past(slot_data))
        else $error("enabled slot not driven with its data");

    a_pdm_only_high: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 pdm_ch_power_on[3:0] == $past(status[3:0]))
        else $error("PDM-only channel power mismatch");

    a_status_readback: assert property (@(posedge clk_sys) disable iff (reset)
        reg_rd && reg_addr == `CPW_ADDR_CHANNEL_POWER_STATUS |=> reg_rdata == $past(status))
        else $error("status read does not show channel power");

    a_reset_defaults: assert property (@(posedge clk_sys)
        reset |=> slot_en_r == `CPW_RST_SLOT_OUTPUT_ENABLE && pwr_r == `CPW_RST_POWER_UP_CONFIG
        && in_en_r == `CPW_RST_INPUT_CHANNEL_ENABLE)
        else $error("register reset values wrong");

    a_in_en_write: assert property (@(posedge clk_sys) disable iff (reset)
        reg_wr && reg_addr == `CPW_ADDR_INPUT_CHANNEL_ENABLE |=> in_en_r == $past(reg_wdata))
        else $error("input enable write did not land");

    a_slot_en_write: assert property (@(posedge clk_sys) disable iff (reset)
        reg_wr && reg_addr == `CPW_ADDR_SLOT_OUTPUT_ENABLE |=> slot_en_r == $past(reg_wdata))
        else $error("slot enable write did not land");

    a_power_cfg_write: assert property (@(posedge clk_sys) disable iff (reset)
        reg_wr && reg_addr == `CPW_ADDR_POWER_UP_CONFIG |=> pwr_r == $past(reg_wdata))
        else $error("power config write did not land");

    a_sdout_idle_low: assert property (@(posedge clk_sys) disable iff (reset)
        !sdout_oe |-> !sdout)
        else $error("serial data not low while slot tri-stated");

    a_source_exclusive: assert property (@(posedge clk_sys) disable iff (reset)
        !(|(analog_ch_power_on & pdm_ch_power_on[7:4])))
        else $error("channel powered as analog and PDM at once");

    a_analog_needs_power: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 !(|(analog_ch_power_on & ~$past(status[7:4]))))
        else $error("analog converter on for a powered-down channel");

    a_outputs_reset_off: assert property (@(posedge clk_sys)
        reset |=> !mic_bias_power_on && !clock_synth_power_on && !(|analog_ch_power_on)
        && pdm_ch_power_on == `CPW_MASK_NONE)
        else $error("power outputs not off after reset");

endmodule

// ==== cpw_top_tb_top.sv ====
// Self-checking bench for the channel power register bank
`include "cpw_cfg.svh"

module cpw_top_tb_top
    import cpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, slot_active, pdm_ch_power_on;
    logic reg_wr, reg_rd, slot_data, sdout, sdout_oe;
    logic mic_bias_power_on, clock_synth_power_on, slot_hit;
    logic [3:0] ch_pdm_select, analog_ch_power_on;
    logic [7:0] grp_left [4] = '{8'hbf, 8'h8f, 8'h83, 8'h80};
    int n_errors = 0;
    int total_checks = 0;

    always #20 clk_sys = ~clk_sys;

    cpw_top i_cpw_top (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ch_pdm_select(ch_pdm_select), .slot_active(slot_active), .slot_data(slot_data),
        .sdout(sdout), .sdout_oe(sdout_oe), .mic_bias_power_on(mic_bias_power_on),
        .clock_synth_power_on(clock_synth_power_on),
        .analog_ch_power_on(analog_ch_power_on), .pdm_ch_power_on(pdm_ch_power_on)
    );

    // ------------------------------------------------------------
    // Access tasks, inputs change on the falling edge only
    // ------------------------------------------------------------
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    // Read data is registered at the read edge and holds, so the next fall is safe
    task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        check_byte(what, exp, reg_rdata);
    endtask

    // Register edge falls inside the write; then status, then outputs: two edges, two spare
    task automatic settle;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ch_pdm_select = 4'h5;
        slot_active = 8'h00;
        slot_data = 1'b0;
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        read_check("input enable", `CPW_ADDR_INPUT_CHANNEL_ENABLE, 8'hf0);
        read_check("slot enable", `CPW_ADDR_SLOT_OUTPUT_ENABLE, 8'h00);
        read_check("power config", `CPW_ADDR_POWER_UP_CONFIG, 8'h00);
        read_check("status", `CPW_ADDR_CHANNEL_POWER_STATUS, 8'h00);
        check_byte("bias", 8'h00, {7'h00, mic_bias_power_on});
        read_check("unmapped", 8'h80, 8'h00);
        reg_write(`CPW_ADDR_CHANNEL_POWER_STATUS, 8'hff);
        read_check("status", `CPW_ADDR_CHANNEL_POWER_STATUS, 8'h00);
        reg_write(`CPW_ADDR_SLOT_OUTPUT_ENABLE, 8'h81);
        read_check("slot enable", `CPW_ADDR_SLOT_OUTPUT_ENABLE, 8'h81);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            slot_active = 8'h80 >> i;
            slot_data = i[0];
            slot_hit = |(slot_active & 8'h81);
            @(negedge clk_sys);
            check_byte("slot oe", {7'h00, slot_hit}, {7'h00, sdout_oe});
            check_byte("sdout", {7'h00, slot_hit & slot_data}, {7'h00, sdout});
        end
        reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'ha0);
        settle;
        check_byte("bias", 8'h01, {7'h00, mic_bias_power_on});
        check_byte("pll", 8'h01, {7'h00, clock_synth_power_on});
        read_check("status", `CPW_ADDR_CHANNEL_POWER_STATUS, 8'h00);
        reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h00);
        settle;
        check_byte("bias", 8'h00, {7'h00, mic_bias_power_on});
        check_byte("pll", 8'h00, {7'h00, clock_synth_power_on});
        // Channels 5 to 8 enabled too: they must never reach the analog side
        reg_write(`CPW_ADDR_INPUT_CHANNEL_ENABLE, 8'hff);
        reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h40);
        settle;
        read_check("status", `CPW_ADDR_CHANNEL_POWER_STATUS, 8'hff);
        check_byte("analog", 8'h0a, {4'h0, analog_ch_power_on});
        check_byte("pdm", 8'h5f, pdm_ch_power_on);
        // Other half of the source select for channels 1-4
        ch_pdm_select = 4'ha;
        settle;
        check_byte("analog", 8'h05, {4'h0, analog_ch_power_on});
        check_byte("pdm", 8'haf, pdm_ch_power_on);
        reg_write(`CPW_ADDR_INPUT_CHANNEL_ENABLE, 8'h0f);
        settle;
        read_check("status", `CPW_ADDR_CHANNEL_POWER_STATUS, 8'hff);
        // Channel 1 stays enabled while live switching is on
        for (int g = 0; g < 4; g++) begin
            reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h40);
            reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h00);
            reg_write(`CPW_ADDR_INPUT_CHANNEL_ENABLE, 8'hff);
            reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h40);
            settle;
            reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h50 | (8'(g) << 2));
            reg_write(`CPW_ADDR_INPUT_CHANNEL_ENABLE, 8'h80);
            settle;
            read_check("group", `CPW_ADDR_CHANNEL_POWER_STATUS, grp_left[g]);
        end
        reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h40);
        reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h00);
        reg_write(`CPW_ADDR_POWER_UP_CONFIG, 8'h10);
        settle;
        read_check("status", `CPW_ADDR_CHANNEL_POWER_STATUS, 8'h00);
        check_byte("pdm", 8'h00, pdm_ch_power_on);
        // Second reset in mid-run must restore the defaults
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        read_check("input enable", `CPW_ADDR_INPUT_CHANNEL_ENABLE, 8'hf0);
        read_check("slot enable", `CPW_ADDR_SLOT_OUTPUT_ENABLE, 8'h00);
        read_check("power config", `CPW_ADDR_POWER_UP_CONFIG, 8'h00);
        check_byte("slot oe", 8'h00, {7'h00, sdout_oe});
        close_out;
    end

    // Cuts a hang short; counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        close_out;
    end

endmodule
